// ===== tecfh_pkg.sv
package tecfh_pkg;

	// ------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [2:0] TECFH_IDX_CAPABILITY = 3'h0;
	localparam logic [2:0] TECFH_IDX_CONFIG = 3'h1;
	localparam logic [2:0] TECFH_IDX_UPPER = 3'h2;
	localparam logic [2:0] TECFH_IDX_LOWER = 3'h3;
	localparam logic [2:0] TECFH_IDX_CRITICAL = 3'h4;
	localparam logic [2:0] TECFH_IDX_TEMP = 3'h5;

	// ------------------------------------------------------------
	// configuration field positions
	// ------------------------------------------------------------
	localparam int TECFH_CFG_MODE = 0;
	localparam int TECFH_CFG_POL = 1;
	localparam int TECFH_CFG_CRIT_ONLY = 2;
	localparam int TECFH_CFG_OUT_EN = 3;
	localparam int TECFH_CFG_STATUS = 4;
	localparam int TECFH_CFG_CLEAR = 5;
	localparam int TECFH_CFG_ALARM_LOCK = 6;
	localparam int TECFH_CFG_CRIT_LOCK = 7;
	localparam int TECFH_CFG_SHUTDOWN = 8;
	localparam int TECFH_CFG_HYST_LO = 9;
	localparam int TECFH_CFG_HYST_HI = 10;

	// temperature readout trip status positions
	localparam int TECFH_TEMP_CRIT = 15;
	localparam int TECFH_TEMP_ABOVE = 14;
	localparam int TECFH_TEMP_BELOW = 13;

	// ------------------------------------------------------------
	// reset values and constants
	// ------------------------------------------------------------
	localparam logic [15:0] TECFH_CAPABILITY_VALUE = 16'h0009;
	localparam logic [12:0] TECFH_LIMIT_RESET = 13'h0000;
	localparam logic TECFH_BIT_RESET = 1'b0;
	localparam logic [1:0] TECFH_HYST_RESET = 2'h0;
	localparam logic [31:0] TECFH_PRDATA_RESET = 32'h00000000;

	// hysteresis in temperature LSBs of 0.0625 degC
	localparam logic [1:0] TECFH_HYST_OFF = 2'h0;
	localparam logic [1:0] TECFH_HYST_1P5 = 2'h1;
	localparam logic [1:0] TECFH_HYST_3P0 = 2'h2;
	localparam logic [1:0] TECFH_HYST_6P0 = 2'h3;
	localparam logic signed [13:0] TECFH_HYS_LSB_1P5 = 14'sh0018;
	localparam logic signed [13:0] TECFH_HYS_LSB_3P0 = 14'sh0030;
	localparam logic signed [13:0] TECFH_HYS_LSB_6P0 = 14'sh0060;
	localparam logic signed [13:0] TECFH_HYS_LSB_0 = 14'sh0000;

endpackage

// ===== tecfh_top.sv
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// [R1] config bit 0: 0 comparator mode (default), 1 interrupt mode
// [R2] config bit 1: 0 active-low event (default), 1 active-high
// [R3] config bit 2: 1 means event only on critical trip
// [R4] alarm lock freezes the critical-only bit
// [R5] config bit 3 enables the event output, default disabled
// [R6] either lock freezes mode, polarity and output enable
// [R7] bit 4 reads 1 while this device asserts an event
// [R8] writing 1 to bit 5 clears an interrupt-mode event
// [R9] clear-event bit always reads back 0
// [R10] clear-event write does nothing in comparator mode
// [R11] alarm lock sticks and blocks upper and lower boundary writes
// [R12] critical lock sticks and blocks critical limit writes
// [R13] locks clear only by power-on reset, never by software
// [R14] one write is enough to set a lock
// [R15] shutdown stops sensing and asserts no events
// [R16] locks refuse setting shutdown but allow clearing it
// [R17] bits 10:9 pick hysteresis: off, 1.5, 3, 6 degC
// [R18] hysteresis also governs event de-assertion; locks freeze it
// [R19] below status sets under lower minus hys, clears at lower
// [R20] above status sets over upper, clears at upper minus hys
// [R21] trip status bits appear in temperature readout
// [R22] cleared interrupt event stays off until next trigger
// [R23] critical trip acts as comparator, software cannot clear it
// [R24] above bit holds until temperature at or below upper minus hys
// [R25] locked fields hold while unlocked fields of same write update
// [R26] event driven only when enabled, with polarity, idle in shutdown
module tecfh_top
	import tecfh_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sample_valid,
	input wire logic [12:0] sample_temp,
	output logic sensing_enable,
	output logic event_out,
	output logic event_oe
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic mode;
		logic pol;
		logic crit_only;
		logic out_en;
		logic alarm_lock;
		logic crit_lock;
		logic shutdown;
		logic [1:0] hyst;
		logic [12:0] upper;
		logic [12:0] lower;
		logic [12:0] crit;
		logic [12:0] temp;
		logic trip_crit;
		logic trip_above;
		logic trip_below;
		logic int_evt;
		logic pin_level;
		logic [31:0] rdata;
	} tecfh_state_type;

	tecfh_state_type state_q;
	tecfh_state_type state_d;

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	logic [2:0] idx;
	logic addr_ok;
	logic ro_reg;
	logic bad_access;
	logic wr_fire;
	logic setup;
	logic any_lock;
	logic signed [13:0] hys;
	logic signed [13:0] t_s;
	logic signed [13:0] up_s;
	logic signed [13:0] lo_s;
	logic signed [13:0] cr_s;
	logic alarm_trig;
	logic crit_rise;
	logic clear_evt;
	logic evt_active;
	logic [15:0] cfg_read;
	logic [15:0] temp_read;

	assign idx = paddr[4:2];
	assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[7:5] == 3'h0) && (idx <= TECFH_IDX_TEMP);
	assign ro_reg = (idx == TECFH_IDX_CAPABILITY) || (idx == TECFH_IDX_TEMP);
	assign bad_access = !addr_ok || (pwrite && ro_reg);
	assign setup = psel && !penable;
	assign wr_fire = psel && penable && pwrite && !bad_access;

	// zero wait states; errors flag unmapped and read-only writes
	assign pready = 1'b1;
	assign pslverr = psel && penable && bad_access;
	assign prdata = state_q.rdata;
	assign any_lock = state_q.alarm_lock || state_q.crit_lock;

	// ------------------------------------------------------------
	// hysteresis and thresholds
	// ------------------------------------------------------------
	// [R17] hysteresis select
	always_comb begin
		unique case (state_q.hyst)
			TECFH_HYST_OFF: hys = TECFH_HYS_LSB_0;
			TECFH_HYST_1P5: hys = TECFH_HYS_LSB_1P5;
			TECFH_HYST_3P0: hys = TECFH_HYS_LSB_3P0;
			TECFH_HYST_6P0: hys = TECFH_HYS_LSB_6P0;
		endcase
	end

	// one guard bit so subtracting hysteresis never wraps
	assign t_s = {sample_temp[12], sample_temp};
	assign up_s = {state_q.upper[12], state_q.upper};
	assign lo_s = {state_q.lower[12], state_q.lower};
	assign cr_s = {state_q.crit[12], state_q.crit};

	// ------------------------------------------------------------
	// readback images
	// ------------------------------------------------------------
	// [R7] status bit shows the asserted event
	// [R9] clear-event bit reads 0
	always_comb begin
		cfg_read = 16'h0000;
		cfg_read[TECFH_CFG_MODE] = state_q.mode;
		cfg_read[TECFH_CFG_POL] = state_q.pol;
		cfg_read[TECFH_CFG_CRIT_ONLY] = state_q.crit_only;
		cfg_read[TECFH_CFG_OUT_EN] = state_q.out_en;
		cfg_read[TECFH_CFG_STATUS] = evt_active;
		cfg_read[TECFH_CFG_CLEAR] = 1'b0;
		cfg_read[TECFH_CFG_ALARM_LOCK] = state_q.alarm_lock;
		cfg_read[TECFH_CFG_CRIT_LOCK] = state_q.crit_lock;
		cfg_read[TECFH_CFG_SHUTDOWN] = state_q.shutdown;
		cfg_read[TECFH_CFG_HYST_HI:TECFH_CFG_HYST_LO] = state_q.hyst;
	end

	// [R21] trip status in temperature readout
	always_comb begin
		temp_read = {3'h0, state_q.temp};
		temp_read[TECFH_TEMP_CRIT] = state_q.trip_crit;
		temp_read[TECFH_TEMP_ABOVE] = state_q.trip_above;
		temp_read[TECFH_TEMP_BELOW] = state_q.trip_below;
	end

	// ------------------------------------------------------------
	// event condition
	// ------------------------------------------------------------
	// [R23] critical trip cannot be cleared by software
	// [R15] no event while shut down
	// [R3] critical-only selection
	// [R1] mode selects comparator or interrupt behaviour
	always_comb begin
		if (state_q.shutdown) begin
			evt_active = 1'b0;
		end else if (state_q.mode) begin
			evt_active = state_q.int_evt || state_q.trip_crit;
		end else if (state_q.crit_only) begin
			evt_active = state_q.trip_crit;
		end else begin
			evt_active = state_q.trip_crit || state_q.trip_above || state_q.trip_below;
		end
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		alarm_trig = 1'b0;
		crit_rise = 1'b0;
		clear_evt = 1'b0;

		if (setup) begin
			unique case (idx)
				TECFH_IDX_CAPABILITY: state_d.rdata = {16'h0000, TECFH_CAPABILITY_VALUE};
				TECFH_IDX_CONFIG: state_d.rdata = {16'h0000, cfg_read};
				TECFH_IDX_UPPER: state_d.rdata = {16'h0000, 3'h0, state_q.upper};
				TECFH_IDX_LOWER: state_d.rdata = {16'h0000, 3'h0, state_q.lower};
				TECFH_IDX_CRITICAL: state_d.rdata = {16'h0000, 3'h0, state_q.crit};
				TECFH_IDX_TEMP: state_d.rdata = {16'h0000, temp_read};
				default: state_d.rdata = TECFH_PRDATA_RESET;
			endcase
			if (!addr_ok || pwrite) begin
				state_d.rdata = TECFH_PRDATA_RESET;
			end
		end

		if (wr_fire && idx == TECFH_IDX_CONFIG) begin
			// [R6] frozen under either lock
			// [R25] unlocked fields still take the write
			if (!any_lock) begin
				state_d.mode = pwdata[TECFH_CFG_MODE];
				state_d.pol = pwdata[TECFH_CFG_POL];
				state_d.out_en = pwdata[TECFH_CFG_OUT_EN];
				// [R18] hysteresis frozen by locks
				state_d.hyst = pwdata[TECFH_CFG_HYST_HI:TECFH_CFG_HYST_LO];
				state_d.shutdown = pwdata[TECFH_CFG_SHUTDOWN];
			end else begin
				// [R16] shutdown may only be cleared while locked
				state_d.shutdown = state_q.shutdown && pwdata[TECFH_CFG_SHUTDOWN];
			end
			// [R4] alarm lock freezes critical-only
			if (!state_q.alarm_lock) begin
				state_d.crit_only = pwdata[TECFH_CFG_CRIT_ONLY];
			end
			// [R13] sticky locks
			// [R14] a single write sets them
			state_d.alarm_lock = state_q.alarm_lock || pwdata[TECFH_CFG_ALARM_LOCK];
			state_d.crit_lock = state_q.crit_lock || pwdata[TECFH_CFG_CRIT_LOCK];
			// [R8] clear only counts in interrupt mode
			// [R10] comparator mode ignores it
			clear_evt = pwdata[TECFH_CFG_CLEAR] && state_q.mode;
		end

		// [R11] alarm lock blocks boundary writes
		if (wr_fire && idx == TECFH_IDX_UPPER && !state_q.alarm_lock) begin
			state_d.upper = pwdata[12:0];
		end
		if (wr_fire && idx == TECFH_IDX_LOWER && !state_q.alarm_lock) begin
			state_d.lower = pwdata[12:0];
		end
		// [R12] critical lock blocks limit writes
		if (wr_fire && idx == TECFH_IDX_CRITICAL && !state_q.crit_lock) begin
			state_d.crit = pwdata[12:0];
		end

		// trips only follow fresh samples while sensing runs
		if (sample_valid && !state_q.shutdown) begin
			state_d.temp = sample_temp;
			// [R18] critical de-assert uses hysteresis
			if (t_s >= cr_s) begin
				state_d.trip_crit = 1'b1;
			end else if (t_s < cr_s - hys) begin
				state_d.trip_crit = 1'b0;
			end
			// [R20] above window set and clear
			// [R24] hold until at or below upper minus hys
			if (t_s > up_s) begin
				state_d.trip_above = 1'b1;
			end else if (t_s <= up_s - hys) begin
				state_d.trip_above = 1'b0;
			end
			// [R19] below window set and clear
			if (t_s < lo_s - hys) begin
				state_d.trip_below = 1'b1;
			end else if (t_s >= lo_s) begin
				state_d.trip_below = 1'b0;
			end
			alarm_trig = (state_d.trip_above != state_q.trip_above) ||
				(state_d.trip_below != state_q.trip_below);
			crit_rise = state_d.trip_crit && !state_q.trip_crit;
		end

		// [R22] cleared event waits for the next trigger; a trigger wins
		if ((alarm_trig && !state_q.crit_only) || crit_rise) begin
			state_d.int_evt = 1'b1;
		end else if (clear_evt) begin
			state_d.int_evt = 1'b0;
		end
		if (!state_q.mode) begin
			state_d.int_evt = 1'b0;
		end

		// [R26] idle unless enabled
		// [R5] output enable gate
		// [R2] polarity
		state_d.pin_level = (state_q.out_en && evt_active) ? state_q.pol : !state_q.pol;
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q.mode <= TECFH_BIT_RESET;
			state_q.pol <= TECFH_BIT_RESET;
			state_q.crit_only <= TECFH_BIT_RESET;
			state_q.out_en <= TECFH_BIT_RESET;
			state_q.alarm_lock <= TECFH_BIT_RESET;
			state_q.crit_lock <= TECFH_BIT_RESET;
			state_q.shutdown <= TECFH_BIT_RESET;
			state_q.hyst <= TECFH_HYST_RESET;
			state_q.upper <= TECFH_LIMIT_RESET;
			state_q.lower <= TECFH_LIMIT_RESET;
			state_q.crit <= TECFH_LIMIT_RESET;
			state_q.temp <= TECFH_LIMIT_RESET;
			state_q.trip_crit <= TECFH_BIT_RESET;
			state_q.trip_above <= TECFH_BIT_RESET;
			state_q.trip_below <= TECFH_BIT_RESET;
			state_q.int_evt <= TECFH_BIT_RESET;
			// idle level of the default active-low pin is high
			state_q.pin_level <= !TECFH_BIT_RESET;
			state_q.rdata <= TECFH_PRDATA_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// [R15] converter disabled in shutdown
	assign sensing_enable = !state_q.shutdown;
	// open drain: only ever pull low, released means high
	assign event_out = 1'b0;
	assign event_oe = !state_q.pin_level;

endmodule

// ===== tecfh_top_checker.sv
`timescale 1ns/1ps
module tecfh_top_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sample_valid,
	input wire logic [12:0] sample_temp,
	input wire logic sensing_enable,
	input wire logic event_out,
	input wire logic event_oe
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic cfg_wr;
	logic acc;
	logic cause;
	assign acc = psel && penable;
	assign cfg_wr = acc && pwrite && paddr == 8'h04;
	assign cause = sample_valid || cfg_wr;
	// ------------------------------------------------------------
	// port relations
	// ------------------------------------------------------------
	a_open_drain: assert property (event_out == 1'b0)
		else $error("event data line driven high");
	a_shutdown_cause: assert property ($fell(sensing_enable) |-> $past(cfg_wr) && $past(pwdata[8]))
		else $error("converter stopped without a shutdown write");
	a_wake_cause: assert property ($rose(sensing_enable) |-> $past(cfg_wr) && !$past(pwdata[8]))
		else $error("converter started without a wake write");
	a_wake_always: assert property (cfg_wr && !pwdata[8] |=> sensing_enable)
		else $error("shutdown clear refused");
	a_pin_cause: assert property ($changed(event_oe) |-> $past(cause) || $past(cause, 2))
		else $error("event pin moved without sample or config write");
	a_ro_refused: assert property (acc && pwrite && (paddr == 8'h00 || paddr == 8'h14) |-> pslverr)
		else $error("write to read-only register accepted");
	a_cfg_accepted: assert property (acc && paddr == 8'h04 |-> pready && !pslverr)
		else $error("config access refused");
	a_clear_reads0: assert property (acc && !pwrite && paddr == 8'h04 |-> prdata[5] == 1'b0)
		else $error("clear bit read back as one");
	c_lock_write: cover property (cfg_wr && pwdata[6]);
	c_pin_rise: cover property ($rose(event_oe));
	c_shutdown: cover property ($fell(sensing_enable));
endmodule
bind tecfh_top tecfh_top_checker tecfh_top_checker_inst (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sample_valid, .sample_temp,
	.sensing_enable, .event_out, .event_oe);

// ===== tecfh_sensor_model.sv
`timescale 1ns/1ps
module tecfh_sensor_model #(
	parameter int PERIOD = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic sensing_enable,
	input wire logic [12:0] target_temp,
	output logic sample_valid,
	output logic [12:0] sample_temp
);
	logic [2:0] tick_q;
	logic fire;
	assign fire = sensing_enable && tick_q == 3'h0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_q <= 3'h0;
			sample_valid <= 1'b0;
			sample_temp <= 13'h0000;
		end else begin
			tick_q <= (tick_q == 3'(PERIOD - 1)) ? 3'h0 : tick_q + 3'h1;
			sample_valid <= fire;
			// data off the strobe toggles so a stale value is never trusted
			sample_temp <= fire ? target_temp : ~sample_temp;
		end
	end
endmodule

// ===== thermal_event_config_hysteresis_bench.sv
`timescale 1ns/1ps
module thermal_event_config_hysteresis_bench
	import tecfh_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [12:0] target_temp = 13'h0080;
	logic [31:0] prdata;
	logic pready, pslverr, sample_valid, sensing_enable, event_out, event_oe;
	logic [12:0] sample_temp;
	logic [31:0] rd_q;
	logic err_q;
	int mismatches = 0;
	int check_count = 0;
	always #25 pclk = ~pclk;
	tecfh_top tecfh_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .sample_valid, .sample_temp, .sensing_enable,
		.event_out, .event_oe);
	tecfh_sensor_model tecfh_sensor_model_inst (.pclk, .presetn, .sensing_enable,
		.target_temp, .sample_valid, .sample_temp);
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic test_done;
		if (mismatches == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (n == 20) begin
			mismatches++;
			test_done();
		end
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic cfg(input logic [31:0] d);
		bus(1'b1, 8'h04, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd_q, exp);
	endtask
	// pin moves one edge after the cause, so look two edges on
	task automatic pin(input logic exp);
		repeat (2) @(posedge pclk);
		chk(32'(event_oe), 32'(exp));
	endtask
	task automatic temp(input logic [12:0] t);
		int n;
		int i;
		@(posedge pclk);
		target_temp <= t;
		n = 0;
		for (i = 0; i < 40 && n < 2; i++) begin
			@(posedge pclk);
			if (sample_valid === 1'b1) n++;
		end
		if (n < 2) begin
			mismatches++;
			test_done();
		end
		repeat (2) @(posedge pclk);
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic sc_reset;
		rdc(8'h04, 32'h0);
		rdc(8'h00, 32'(TECFH_CAPABILITY_VALUE));
		bus(1'b0, 8'h1C, 32'h0);
		chk(32'(err_q), 32'h1);
		bus(1'b1, 8'h14, 32'h1234);
		chk(32'(err_q), 32'h1);
		chk(32'(sensing_enable), 32'h1);
		chk(32'(event_oe), 32'h0);
		chk(32'(event_out), 32'h0);
	endtask
	task automatic sc_compare;
		bus(1'b1, 8'h08, 32'h100);
		bus(1'b1, 8'h10, 32'h200);
		cfg(32'h8);
		temp(13'h080);
		pin(1'b0);
		rdc(8'h14, 32'h0080);
		temp(13'h150);
		pin(1'b1);
		rdc(8'h14, 32'h4150);
		rdc(8'h04, 32'h18);
		cfg(32'h28);
		pin(1'b1);
		rdc(8'h04, 32'h18);
		cfg(32'h0);
		pin(1'b0);
		cfg(32'hC);
		pin(1'b0);
		temp(13'h220);
		pin(1'b1);
		rdc(8'h14, 32'hC220);
		temp(13'h150);
		pin(1'b0);
		cfg(32'h8);
		temp(13'h100);
		pin(1'b0);
	endtask
	task automatic sc_hyst;
		logic [12:0] hy [4];
		int k;
		hy = '{13'h000, 13'h018, 13'h030, 13'h060};
		for (k = 0; k < 4; k++) begin
			cfg(32'h8 | (32'(k) << 9));
			temp(13'h150);
			temp(13'h101 - hy[k]);
			rdc(8'h14, 32'h4101 - 32'(hy[k]));
			temp(13'h100 - hy[k]);
			rdc(8'h14, 32'h0100 - 32'(hy[k]));
		end
		cfg(32'h208);
		temp(13'h1FE9);
		rdc(8'h14, 32'h1FE9);
		temp(13'h1FE0);
		rdc(8'h14, 32'h3FE0);
		pin(1'b1);
		temp(13'h1FFF);
		rdc(8'h14, 32'h3FFF);
		temp(13'h0000);
		rdc(8'h14, 32'h0);
	endtask
	task automatic sc_interrupt;
		cfg(32'h9);
		temp(13'h080);
		cfg(32'h29);
		pin(1'b0);
		temp(13'h150);
		pin(1'b1);
		cfg(32'h29);
		pin(1'b0);
		temp(13'h150);
		pin(1'b0);
		temp(13'h220);
		pin(1'b1);
		cfg(32'h29);
		pin(1'b1);
		cfg(32'hB);
		pin(1'b0);
		temp(13'h080);
		cfg(32'h2B);
		pin(1'b1);
		cfg(32'h8);
	endtask
	task automatic sc_shutdown;
		temp(13'h150);
		cfg(32'h108);
		pin(1'b0);
		chk(32'(sensing_enable), 32'h0);
		rdc(8'h04, 32'h108);
		cfg(32'h8);
		// the converter enable moves at the write edge, so look one edge later
		@(posedge pclk);
		chk(32'(sensing_enable), 32'h1);
		temp(13'h080);
	endtask
	task automatic sc_locks;
		cfg(32'h108);
		cfg(32'h148);
		rdc(8'h04, 32'h148);
		cfg(32'h48);
		rdc(8'h04, 32'h48);
		cfg(32'h148);
		rdc(8'h04, 32'h48);
		bus(1'b1, 8'h08, 32'h180);
		rdc(8'h08, 32'h100);
		bus(1'b1, 8'h0C, 32'h10);
		rdc(8'h0C, 32'h0);
		cfg(32'h607);
		rdc(8'h04, 32'h48);
		cfg(32'h88);
		rdc(8'h04, 32'hC8);
		bus(1'b1, 8'h10, 32'h300);
		rdc(8'h10, 32'h200);
	endtask
	// a second power-on reset is the only way out of the locks
	task automatic sc_power_on;
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rdc(8'h04, 32'h0);
		bus(1'b1, 8'h08, 32'h180);
		rdc(8'h08, 32'h180);
		bus(1'b1, 8'h10, 32'h300);
		rdc(8'h10, 32'h300);
	endtask
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		sc_reset();
		sc_compare();
		sc_hyst();
		sc_interrupt();
		sc_shutdown();
		sc_locks();
		sc_power_on();
		test_done();
	end
endmodule
